/* File: serial_ctrl_pkg.sv */
// constants, codes and carrier types for the serial control port and pin function map
package serial_ctrl_pkg;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 24;
	localparam int ADDR_BITS = 7;
	localparam int DATA_BITS = 16;
	localparam int INSTR_BITS = 8;
	localparam int RW_POS = 23;
	localparam int ADDR_HI = 22;
	localparam int ADDR_LO = 16;
	localparam int DATA_HI = 15;
	localparam int COUNT_BITS = 5;
	localparam logic [COUNT_BITS-1:0] FRAME_COUNT_FULL = 5'h18;
	localparam logic [COUNT_BITS-1:0] FRAME_COUNT_RESET = 5'h00;
	localparam logic RW_WRITE = 1'h0;
	localparam logic RW_READ = 1'h1;

	// ----------------------------------------------------------------
	// pin function codes
	// ----------------------------------------------------------------
	localparam int CODE_BITS = 4;
	localparam int CHANNELS = 3;
	localparam logic [3:0] IN_FUNC_GEN = 4'h9;
	localparam logic [3:0] IN_MARGIN = 4'hA;
	localparam logic [3:0] IN_RESET = 4'hB;
	localparam logic [3:0] IN_NVM_GATE = 4'hC;
	localparam logic [3:0] IN_REG_LOCK = 4'hD;
	localparam logic [3:0] OUT_DATA_READY = 4'h0;
	localparam logic [3:0] OUT_NONVOLATILE_BUSY = 4'h1;
	localparam logic [3:0] OUT_DAC2_BUSY = 4'h4;
	localparam logic [3:0] OUT_DAC0_BUSY = 4'h6;
	localparam logic [3:0] OUT_DAC1_BUSY = 4'h7;
	localparam logic [3:0] OUT_WINDOW_CMP = 4'hB;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic NVM_ALLOW_RESET = 1'h1;
	localparam logic REG_LOCK_RESET = 1'h0;
	localparam logic PIN_IDLE_HIGH = 1'h1;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IF_UNDECIDED = 2'h0,
		IF_SERIAL = 2'h1,
		IF_TWO_WIRE = 2'h3
	} interface_type_t;

	typedef struct packed {
		logic rw;
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} frame_t;

	typedef struct packed {
		logic [CHANNELS-1:0] func_stop;
		logic [CHANNELS-1:0] func_start;
		logic [CHANNELS-1:0] margin_low;
		logic [CHANNELS-1:0] margin_high;
	} pin_event_t;

endpackage : serial_ctrl_pkg

/* File: pin_sync.sv */
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync width must be at least one");
	end

	// ----------------------------------------------------------------
	// first stage read only by second stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= INIT;
			sync_out <= INIT;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : pin_sync

/* File: pin_function_map.sv */
// decode of general-purpose pin input events and output status selection
`timescale 1ns/10ps
module pin_function_map (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_rise,
	input wire logic pin_fall,
	input wire logic [3:0] pin_input_function_code,
	input wire logic [3:0] pin_output_function_code,
	input wire logic [2:0] pin_channel_select,
	input wire logic converter_data_ready,
	input wire logic nonvolatile_busy,
	input wire logic [2:0] dac_busy,
	input wire logic window_comparator_result,
	output serial_ctrl_pkg::pin_event_t events,
	output logic nvm_allow,
	output logic reg_lock,
	output logic device_reset,
	output logic status_level
);
	logic reset_armed;

	// ----------------------------------------------------------------
	// edge-triggered input functions
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			events <= '0;
		end else begin
			events <= '0;
			if (pin_input_function_code == serial_ctrl_pkg::IN_FUNC_GEN) begin
				events.func_stop <= pin_fall ? pin_channel_select : 3'h0;
				events.func_start <= pin_rise ? pin_channel_select : 3'h0;
			end
			if (pin_input_function_code == serial_ctrl_pkg::IN_MARGIN) begin
				events.margin_low <= pin_fall ? pin_channel_select : 3'h0;
				events.margin_high <= pin_rise ? pin_channel_select : 3'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			nvm_allow <= serial_ctrl_pkg::NVM_ALLOW_RESET;
		end else if (pin_input_function_code == serial_ctrl_pkg::IN_NVM_GATE) begin
			if (pin_fall) begin
				nvm_allow <= 1'h1;
			end else if (pin_rise) begin
				nvm_allow <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_lock <= serial_ctrl_pkg::REG_LOCK_RESET;
		end else if (pin_input_function_code == serial_ctrl_pkg::IN_REG_LOCK) begin
			if (pin_fall) begin
				reg_lock <= 1'h0;
			end else if (pin_rise) begin
				reg_lock <= 1'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// reset on a full low pulse only
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_armed <= 1'h0;
			device_reset <= 1'h0;
		end else if (pin_input_function_code != serial_ctrl_pkg::IN_RESET) begin
			reset_armed <= 1'h0;
			device_reset <= 1'h0;
		end else begin
			device_reset <= pin_rise & reset_armed;
			if (pin_fall) begin
				reset_armed <= 1'h1;
			end else if (pin_rise) begin
				reset_armed <= 1'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// status output selection
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			status_level <= 1'h0;
		end else begin
			case (pin_output_function_code)
				serial_ctrl_pkg::OUT_DATA_READY: status_level <= converter_data_ready;
				serial_ctrl_pkg::OUT_NONVOLATILE_BUSY: status_level <= nonvolatile_busy;
				serial_ctrl_pkg::OUT_DAC2_BUSY: status_level <= dac_busy[2];
				serial_ctrl_pkg::OUT_DAC0_BUSY: status_level <= dac_busy[0];
				serial_ctrl_pkg::OUT_DAC1_BUSY: status_level <= dac_busy[1];
				serial_ctrl_pkg::OUT_WINDOW_CMP: status_level <= window_comparator_result;
				default: status_level <= 1'h0;
			endcase
		end
	end
endmodule : pin_function_map

/* File: serial_ctrl_port_gpio_map.sv */
// serial control port receiver with interface type latch and shared pin handling
`timescale 1ns/10ps
module serial_ctrl_port_gpio_map #(
	parameter logic [6:0] UNLOCK_ADDR = 7'h00
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic FRAME_SEL_N,
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_IN_LINE,
	input wire logic GPIO_IN,
	output logic GPIO_OUT,
	output logic GPIO_OE,
	input wire logic TWO_WIRE_ACTIVITY,
	input wire logic SERIAL_OUT_ENABLE,
	input wire logic PIN_INPUT_ENABLE,
	input wire logic PIN_OUTPUT_ENABLE,
	input wire logic [3:0] PIN_INPUT_FUNCTION_CODE,
	input wire logic [3:0] PIN_OUTPUT_FUNCTION_CODE,
	input wire logic [2:0] PIN_CHANNEL_SELECT,
	input wire logic CONVERTER_DATA_READY,
	input wire logic NONVOLATILE_BUSY,
	input wire logic [2:0] DAC_BUSY,
	input wire logic WINDOW_COMPARATOR_RESULT,
	input wire logic [15:0] READ_DATA,
	output serial_ctrl_pkg::frame_t ACCESS,
	output logic ACCESS_WRITE,
	output logic ACCESS_READ,
	output logic WRITE_BLOCKED,
	output serial_ctrl_pkg::pin_event_t PIN_EVENTS,
	output logic NVM_PROGRAM_ALLOW,
	output logic REGISTER_LOCK,
	output logic DEVICE_RESET,
	output logic [1:0] INTERFACE_TYPE
);
	localparam int FB = serial_ctrl_pkg::FRAME_BITS;

	logic sel_n_s;
	logic sclk_s;
	logic serial_in_s;
	logic gpio_s;
	logic sel_n_d;
	logic sclk_d;
	logic gpio_d;
	logic sel_fall;
	logic sel_rise;
	logic sclk_fall;
	logic sample_edge;
	logic frame_done;
	logic write_allowed;
	logic pin_is_input;
	logic [FB-1:0] in_shift;
	logic [FB-1:0] out_shift;
	logic [FB-1:0] next_in_shift;
	logic [serial_ctrl_pkg::COUNT_BITS-1:0] bit_count;
	logic echo_rw;
	logic [serial_ctrl_pkg::ADDR_BITS-1:0] echo_addr;
	logic [serial_ctrl_pkg::DATA_BITS-1:0] echo_data;
	logic status_level;
	serial_ctrl_pkg::interface_type_t if_state;

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	pin_sync #(
		.WIDTH(4),
		.INIT({serial_ctrl_pkg::PIN_IDLE_HIGH, 3'h0})
	) u_sync (
		.clk(CLK),
		.rst(RST),
		.async_in({FRAME_SEL_N, SERIAL_CLK, SERIAL_IN_LINE, GPIO_IN}),
		.sync_out({sel_n_s, sclk_s, serial_in_s, gpio_s})
	);

	always_ff @(posedge CLK) begin
		if (RST) begin
			sel_n_d <= serial_ctrl_pkg::PIN_IDLE_HIGH;
			sclk_d <= 1'h0;
			gpio_d <= 1'h0;
		end else begin
			sel_n_d <= sel_n_s;
			sclk_d <= sclk_s;
			gpio_d <= gpio_s;
		end
	end

	assign sel_fall = sel_n_d & ~sel_n_s;
	assign sel_rise = ~sel_n_d & sel_n_s;
	assign sclk_fall = sclk_d & ~sclk_s;
	assign sample_edge = sclk_fall & ~sel_n_s & (if_state == serial_ctrl_pkg::IF_SERIAL);

	// ----------------------------------------------------------------
	// interface type latch
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			if_state <= serial_ctrl_pkg::IF_UNDECIDED;
		end else begin
			case (if_state)
				serial_ctrl_pkg::IF_UNDECIDED: begin
					if (sel_fall) begin
						if_state <= serial_ctrl_pkg::IF_SERIAL;
					end else if (TWO_WIRE_ACTIVITY) begin
						if_state <= serial_ctrl_pkg::IF_TWO_WIRE;
					end
				end
				serial_ctrl_pkg::IF_SERIAL: if_state <= serial_ctrl_pkg::IF_SERIAL;
				serial_ctrl_pkg::IF_TWO_WIRE: if_state <= serial_ctrl_pkg::IF_TWO_WIRE;
				default: if_state <= serial_ctrl_pkg::IF_UNDECIDED;
			endcase
		end
	end

	assign INTERFACE_TYPE = if_state;

	// ----------------------------------------------------------------
	// frame receiver
	// ----------------------------------------------------------------
	assign next_in_shift = {in_shift[FB-2:0], serial_in_s};

	always_ff @(posedge CLK) begin
		if (RST) begin
			in_shift <= '0;
			bit_count <= serial_ctrl_pkg::FRAME_COUNT_RESET;
		end else if (sel_fall) begin
			bit_count <= serial_ctrl_pkg::FRAME_COUNT_RESET;
		end else if (sample_edge) begin
			if (bit_count != serial_ctrl_pkg::FRAME_COUNT_FULL) begin
				in_shift <= next_in_shift;
				bit_count <= bit_count + 5'h01;
			end else if (SERIAL_OUT_ENABLE) begin
				in_shift <= next_in_shift;
			end
			// three-wire: bits past the 24th are dropped
		end
	end

	// frame acts only at frame select rise with a full count
	assign frame_done = sel_rise & (bit_count == serial_ctrl_pkg::FRAME_COUNT_FULL)
		& (if_state == serial_ctrl_pkg::IF_SERIAL);
	// lock leaves only the unlock field writable
	assign write_allowed = ~REGISTER_LOCK
		| (in_shift[serial_ctrl_pkg::ADDR_HI:serial_ctrl_pkg::ADDR_LO] == UNLOCK_ADDR);

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			ACCESS <= '0;
			ACCESS_WRITE <= 1'h0;
			ACCESS_READ <= 1'h0;
			WRITE_BLOCKED <= 1'h0;
		end else begin
			ACCESS_WRITE <= 1'h0;
			ACCESS_READ <= 1'h0;
			WRITE_BLOCKED <= 1'h0;
			if (frame_done) begin
				ACCESS.rw <= in_shift[serial_ctrl_pkg::RW_POS];
				ACCESS.addr <= in_shift[serial_ctrl_pkg::ADDR_HI:serial_ctrl_pkg::ADDR_LO];
				ACCESS.data <= in_shift[serial_ctrl_pkg::DATA_HI:0];
				if (in_shift[serial_ctrl_pkg::RW_POS] == serial_ctrl_pkg::RW_WRITE) begin
					ACCESS_WRITE <= write_allowed;
					WRITE_BLOCKED <= ~write_allowed;
				end else begin
					ACCESS_READ <= 1'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// readback echo of the previous access
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			echo_rw <= 1'h0;
			echo_addr <= '0;
			echo_data <= '0;
		end else if (frame_done) begin
			echo_rw <= in_shift[serial_ctrl_pkg::RW_POS];
			echo_addr <= in_shift[serial_ctrl_pkg::ADDR_HI:serial_ctrl_pkg::ADDR_LO];
			echo_data <= in_shift[serial_ctrl_pkg::DATA_HI:0];
		end else if (ACCESS_READ) begin
			echo_data <= READ_DATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			out_shift <= '0;
		end else if (sel_fall) begin
			out_shift <= {echo_rw, echo_addr, echo_data};
		end else if (sample_edge) begin
			out_shift <= {out_shift[FB-2:0], 1'h0};
		end
	end

	// ----------------------------------------------------------------
	// shared pin functions
	// ----------------------------------------------------------------
	assign pin_is_input = PIN_INPUT_ENABLE & ~SERIAL_OUT_ENABLE;

	pin_function_map u_pin_map (
		.clk(CLK),
		.rst(RST),
		.pin_rise(pin_is_input & ~gpio_d & gpio_s),
		.pin_fall(pin_is_input & gpio_d & ~gpio_s),
		.pin_input_function_code(PIN_INPUT_FUNCTION_CODE),
		.pin_output_function_code(PIN_OUTPUT_FUNCTION_CODE),
		.pin_channel_select(PIN_CHANNEL_SELECT),
		.converter_data_ready(CONVERTER_DATA_READY),
		.nonvolatile_busy(NONVOLATILE_BUSY),
		.dac_busy(DAC_BUSY),
		.window_comparator_result(WINDOW_COMPARATOR_RESULT),
		.events(PIN_EVENTS),
		.nvm_allow(NVM_PROGRAM_ALLOW),
		.reg_lock(REGISTER_LOCK),
		.device_reset(DEVICE_RESET),
		.status_level(status_level)
	);

	always_ff @(posedge CLK) begin
		if (RST) begin
			GPIO_OUT <= 1'h0;
			GPIO_OE <= 1'h0;
		end else if (SERIAL_OUT_ENABLE) begin
			GPIO_OUT <= out_shift[FB-1];
			GPIO_OE <= ~sel_n_s & (if_state == serial_ctrl_pkg::IF_SERIAL);
		end else if (PIN_OUTPUT_ENABLE & ~PIN_INPUT_ENABLE) begin
			GPIO_OUT <= status_level;
			GPIO_OE <= 1'h1;
		end else begin
			GPIO_OUT <= 1'h0;
			GPIO_OE <= 1'h0;
		end
	end
endmodule : serial_ctrl_port_gpio_map

/* File: spi_host_model.sv */
// serial host model driving frames onto the control port pins
`timescale 1ns/10ps
module spi_host_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [23:0] word,
	input wire logic [5:0] nbits,
	input wire logic serial_out_line,
	output logic sel_n,
	output logic sclk,
	output logic serial_in_line,
	output logic busy,
	output logic [23:0] rx
);
	initial begin
		sel_n = 1'h1;
		sclk = 1'h1;
		serial_in_line = 1'h0;
		busy = 1'h0;
		rx = 24'h000000;
	end
	// ----------------------------------------------------------------
	// one frame per request, clock stands high between frames
	// ----------------------------------------------------------------
	always @(posedge clk) begin : frame
		int i;
		if (go && !busy) begin
			busy <= 1'h1;
			sel_n <= 1'h0;
			repeat (4) @(posedge clk);
			for (i = 0; i < nbits; i++) begin
				serial_in_line <= (i < 24) ? word[23 - i] : ~serial_in_line;
				repeat (4) @(posedge clk);
				sclk <= 1'h0;
				rx <= {rx[22:0], serial_out_line};
				repeat (4) @(posedge clk);
				sclk <= 1'h1;
			end
			repeat (4) @(posedge clk);
			sel_n <= 1'h1;
			serial_in_line <= ~serial_in_line;
			repeat (4) @(posedge clk);
			busy <= 1'h0;
		end
	end
endmodule : spi_host_model

/* File: serial_ctrl_props.sv */
// concurrent checks on the serial control port boundary
`timescale 1ns/10ps
module serial_ctrl_props #(
	parameter logic [6:0] UNLOCK_ADDR = 7'h00
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic FRAME_SEL_N,
	input wire logic SERIAL_OUT_ENABLE,
	input wire logic PIN_OUTPUT_ENABLE,
	input wire logic [3:0] PIN_INPUT_FUNCTION_CODE,
	input wire logic [2:0] PIN_CHANNEL_SELECT,
	input wire logic GPIO_OE,
	input wire serial_ctrl_pkg::frame_t ACCESS,
	input wire logic ACCESS_WRITE,
	input wire logic ACCESS_READ,
	input wire logic WRITE_BLOCKED,
	input wire serial_ctrl_pkg::pin_event_t PIN_EVENTS,
	input wire logic NVM_PROGRAM_ALLOW,
	input wire logic REGISTER_LOCK,
	input wire logic DEVICE_RESET,
	input wire logic [1:0] INTERFACE_TYPE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	logic strobe;
	assign strobe = ACCESS_WRITE | ACCESS_READ | WRITE_BLOCKED;
	sequence sel_idle_s;
		(FRAME_SEL_N && SERIAL_OUT_ENABLE) [*6];
	endsequence
	sequence quiet_pin_s;
		(!SERIAL_OUT_ENABLE && !PIN_OUTPUT_ENABLE) [*3];
	endsequence
	a_one_strobe: assert property ($onehot0({ACCESS_WRITE, ACCESS_READ, WRITE_BLOCKED}))
		else $error("more than one access strobe");
	a_write_dir: assert property (ACCESS_WRITE |-> ACCESS.rw == serial_ctrl_pkg::RW_WRITE)
		else $error("write strobe with read direction");
	a_read_dir: assert property (ACCESS_READ |-> ACCESS.rw == serial_ctrl_pkg::RW_READ)
		else $error("read strobe with write direction");
	a_access_hold: assert property (!strobe |-> $stable(ACCESS))
		else $error("access changed without a strobe");
	a_lock_gate: assert property (ACCESS_WRITE |-> !$past(REGISTER_LOCK) || ACCESS.addr == UNLOCK_ADDR)
		else $error("write passed while locked");
	a_type_sticky: assert property (INTERFACE_TYPE != 2'h0 |=> $stable(INTERFACE_TYPE))
		else $error("interface type changed");
	a_out_released: assert property (sel_idle_s |-> !GPIO_OE)
		else $error("serial out driven while deselected");
	a_three_wire_off: assert property (quiet_pin_s |-> !GPIO_OE)
		else $error("pin driven in three-wire mode");
	a_reset_cause: assert property (DEVICE_RESET |-> $past(PIN_INPUT_FUNCTION_CODE) == 4'hB)
		else $error("device reset without reset code");
	a_event_mask: assert property (|PIN_EVENTS |-> ((PIN_EVENTS.func_stop
		| PIN_EVENTS.func_start | PIN_EVENTS.margin_low | PIN_EVENTS.margin_high)
		& ~$past(PIN_CHANNEL_SELECT)) == 3'h0)
		else $error("event on unselected channel");
endmodule : serial_ctrl_props
bind serial_ctrl_port_gpio_map serial_ctrl_props #(.UNLOCK_ADDR(UNLOCK_ADDR)) i_props (.CLK(CLK),
	.RST(RST), .FRAME_SEL_N(FRAME_SEL_N), .SERIAL_OUT_ENABLE(SERIAL_OUT_ENABLE),
	.PIN_OUTPUT_ENABLE(PIN_OUTPUT_ENABLE), .PIN_INPUT_FUNCTION_CODE(PIN_INPUT_FUNCTION_CODE),
	.PIN_CHANNEL_SELECT(PIN_CHANNEL_SELECT), .GPIO_OE(GPIO_OE), .ACCESS(ACCESS),
	.ACCESS_WRITE(ACCESS_WRITE), .ACCESS_READ(ACCESS_READ), .WRITE_BLOCKED(WRITE_BLOCKED),
	.PIN_EVENTS(PIN_EVENTS), .NVM_PROGRAM_ALLOW(NVM_PROGRAM_ALLOW), .REGISTER_LOCK(REGISTER_LOCK),
	.DEVICE_RESET(DEVICE_RESET), .INTERFACE_TYPE(INTERFACE_TYPE));

/* File: test_serial_ctrl_port_gpio_map.sv */
// self-checking bench for the serial control port and pin function map
`timescale 1ns/10ps
module test_serial_ctrl_port_gpio_map;
	localparam logic [6:0] UNLOCK = 7'h12;
	logic clk = 1'h0, rst = 1'h1, go = 1'h0, pin_drv = 1'h1, two_wire = 1'h0;
	logic four_wire = 1'h0, in_en = 1'h0, out_en = 1'h0;
	logic [3:0] in_code = 4'h0, out_code = 4'h0;
	logic [2:0] ch_sel = 3'h0;
	logic [5:0] st = 6'h00, nbits = 6'h18;
	logic [15:0] rd_data = 16'h0000;
	logic [23:0] word = 24'h000000, w, rx, prev;
	logic sel_n, sclk, serial_in, busy, gpio_out, gpio_oe, gpio_line, acc_wr, acc_rd, wr_blk;
	logic nvm_allow, reg_lock, dev_rst;
	logic [1:0] if_type;
	serial_ctrl_pkg::frame_t access;
	serial_ctrl_pkg::pin_event_t events, ev;
	logic [7:0] cnt [4] = '{default: 8'h00};
	logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'hB, 4'h2};
	logic [31:0] seed = 32'hD2DC, r;
	int miscompares = 0, n_tests = 0, k;

	always #20 clk = ~clk;
	assign gpio_line = gpio_oe ? gpio_out : pin_drv;

	serial_ctrl_port_gpio_map #(.UNLOCK_ADDR(UNLOCK)) i_dut (.CLK(clk), .RST(rst),
		.FRAME_SEL_N(sel_n), .SERIAL_CLK(sclk), .SERIAL_IN_LINE(serial_in), .GPIO_IN(gpio_line),
		.GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .TWO_WIRE_ACTIVITY(two_wire),
		.SERIAL_OUT_ENABLE(four_wire), .PIN_INPUT_ENABLE(in_en), .PIN_OUTPUT_ENABLE(out_en),
		.PIN_INPUT_FUNCTION_CODE(in_code), .PIN_OUTPUT_FUNCTION_CODE(out_code),
		.PIN_CHANNEL_SELECT(ch_sel), .CONVERTER_DATA_READY(st[5]), .NONVOLATILE_BUSY(st[4]),
		.DAC_BUSY(st[3:1]), .WINDOW_COMPARATOR_RESULT(st[0]), .READ_DATA(rd_data),
		.ACCESS(access), .ACCESS_WRITE(acc_wr), .ACCESS_READ(acc_rd), .WRITE_BLOCKED(wr_blk),
		.PIN_EVENTS(events), .NVM_PROGRAM_ALLOW(nvm_allow), .REGISTER_LOCK(reg_lock),
		.DEVICE_RESET(dev_rst), .INTERFACE_TYPE(if_type));
	spi_host_model i_host (.clk(clk), .go(go), .word(word), .nbits(nbits),
		.serial_out_line(gpio_line), .sel_n(sel_n), .sclk(sclk), .serial_in_line(serial_in),
		.busy(busy), .rx(rx));

	// ----------------------------------------------------------------
	// strobe counters and helpers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cnt[0] <= cnt[0] + {7'h00, acc_wr};
		cnt[1] <= cnt[1] + {7'h00, acc_rd};
		cnt[2] <= cnt[2] + {7'h00, wr_blk};
		cnt[3] <= cnt[3] + {7'h00, dev_rst};
		ev <= ev | events;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic exp_status(input logic [3:0] c, input logic [5:0] s);
		case (c)
			serial_ctrl_pkg::OUT_DATA_READY: return s[5];
			serial_ctrl_pkg::OUT_NONVOLATILE_BUSY: return s[4];
			serial_ctrl_pkg::OUT_DAC2_BUSY: return s[3];
			serial_ctrl_pkg::OUT_DAC1_BUSY: return s[2];
			serial_ctrl_pkg::OUT_DAC0_BUSY: return s[1];
			serial_ctrl_pkg::OUT_WINDOW_CMP: return s[0];
			default: return 1'h0;
		endcase
	endfunction : exp_status
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic clear();
		@(negedge clk);
		cnt = '{default: 8'h00};
		ev = 12'h000;
	endtask : clear
	task automatic send(input logic [23:0] v, input logic [5:0] nb);
		clear();
		@(posedge clk);
		word <= v;
		nbits <= nb;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		@(posedge clk);
		while (busy) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask : send
	task automatic pin(input logic v);
		@(posedge clk);
		pin_drv <= v;
		repeat (6) @(posedge clk);
	endtask : pin
	task automatic power();
		rst <= 1'h1;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
	endtask : power

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		power();
		chk("if_type", 2'h0, if_type);
		chk("nvm_allow", 1'h1, nvm_allow);
		chk("oe_idle", 1'h0, gpio_oe);
		for (k = 0; k < 4; k++) begin
			r = rnd();
			w = {1'h0, r[22:0]};
			send(w, 6'h18);
			chk("write", w, access);
			chk("write_cnt", 1'h1, cnt[0]);
		end
		chk("if_type", serial_ctrl_pkg::IF_SERIAL, if_type);
		r = rnd();
		send({1'h0, r[22:0]}, 6'h17);
		chk("short", w, access);
		chk("short_cnt", 1'h0, cnt[0]);
		w = {1'h0, r[22:0]} ^ 24'h0F0F0F;
		send(w, 6'h1E);
		chk("long", w, access);
		rd_data <= r[31:16];
		w = {1'h1, r[22:0]};
		send(w, 6'h18);
		chk("read_cnt", 1'h1, cnt[1]);
		chk("read_addr", w[23:16], access[23:16]);
		four_wire <= 1'h1;
		send(w, 6'h18);
		prev = w;
		w = {1'h0, r[30:8]};
		send(w, 6'h18);
		chk("echo_read", {prev[23:16], rd_data}, rx);
		send(prev, 6'h18);
		chk("echo_write", w, rx);
		four_wire <= 1'h0;
		in_en <= 1'h1;
		ch_sel <= r[2:0] | 3'h1;
		for (k = 0; k < 2; k++) begin
			in_code <= k ? serial_ctrl_pkg::IN_MARGIN : serial_ctrl_pkg::IN_FUNC_GEN;
			clear();
			pin(1'h0);
			pin(1'h1);
			chk("events", k ? {6'h00, ch_sel, ch_sel} : {ch_sel, ch_sel, 6'h00}, ev);
		end
		in_code <= serial_ctrl_pkg::IN_NVM_GATE;
		pin(1'h0);
		pin(1'h1);
		chk("nvm_block", 1'h0, nvm_allow);
		pin(1'h0);
		chk("nvm_allow", 1'h1, nvm_allow);
		in_code <= serial_ctrl_pkg::IN_REG_LOCK;
		pin(1'h1);
		chk("lock", 1'h1, reg_lock);
		send({1'h0, ~UNLOCK, r[15:0]}, 6'h18);
		chk("blocked", 1'h1, cnt[2]);
		send({1'h0, UNLOCK, r[15:0]}, 6'h18);
		chk("unlock_write", 1'h1, cnt[0]);
		pin(1'h0);
		chk("unlock", 1'h0, reg_lock);
		in_code <= serial_ctrl_pkg::IN_RESET;
		clear();
		pin(1'h1);
		chk("rise_only", 1'h0, cnt[3]);
		pin(1'h0);
		pin(1'h1);
		chk("low_pulse", 1'h1, cnt[3]);
		in_en <= 1'h0;
		out_en <= 1'h1;
		for (k = 0; k < 7; k++) begin
			r = rnd();
			out_code <= codes[k];
			st <= r[5:0];
			repeat (3) @(posedge clk);
			chk("status", exp_status(codes[k], r[5:0]), gpio_out);
			chk("status_oe", 1'h1, gpio_oe);
		end
		out_en <= 1'h0;
		power();
		two_wire <= 1'h1;
		@(posedge clk);
		two_wire <= 1'h0;
		repeat (3) @(posedge clk);
		chk("two_wire", serial_ctrl_pkg::IF_TWO_WIRE, if_type);
		send(w, 6'h18);
		chk("ignored", 1'h0, cnt[0] | cnt[1]);
		chk("two_wire", serial_ctrl_pkg::IF_TWO_WIRE, if_type);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule : test_serial_ctrl_port_gpio_map
